/* File: spi_consts.svh */
/*
 * Offsets, field positions, reset values and timing counts of the
 * slave-select serial channel.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef SPI_CONSTS_SVH
`define SPI_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets (APB, one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define OFF_DATA     12'h000
`define OFF_MODE     12'h004
`define OFF_START    12'h008
`define OFF_STOP     12'h00C
`define OFF_STATUS   12'h010
`define OFF_FLAGCLR  12'h014
`define OFF_OUTEN    12'h018
`define OFF_INSW     12'h01C
`define OFF_PERIPH   12'h020

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MODE_TXRX    0
`define MODE_CONT    1
`define MODE_DAP     2
`define MODE_CKP     3
`define MODE_LSB     4
`define MODE_LEN7    5
`define TRIG_CH0     0
`define ST_OPEN      0
`define ST_TSF       1
`define ST_OVF       2
`define ST_TXFULL    3
`define ST_RXFULL    4
`define INSW_SEL_EN  7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define MODE_RST     6'h00
`define INSW_RST     8'h00
`define IDLE_OUT     1'h1
`define FMCK_DIV     1
`define MCK_PER_SCK  6

`endif

/* File: spi_pkg.sv */
/*
 * Types of the slave-select serial channel.
 * Assumes nothing beyond the constants header.
 */
package spi_pkg;

   // -------------------------------------------------------------------
   // Frame state, channel state and synchroniser state
   // -------------------------------------------------------------------
   typedef enum logic {ST_IDLE, ST_FRAME} link_state_t;

   typedef struct packed {
      logic        per_en;
      logic [5:0]  mode;
      logic [7:0]  insw;
      logic        soe;
      logic        op_en;
      link_state_t lstate;
      logic [2:0]  bitcnt;
      logic [7:0]  tx_buf;
      logic        tx_full;
      logic [7:0]  tx_sh;
      logic [7:0]  rx_sh;
      logic [7:0]  rx_data;
      logic        rx_full;
      logic        ovf;
      logic        sck_prev;
      logic        sdo;
      logic        irq;
      logic [31:0] prdata;
   } chan_state_t;

   typedef struct packed {
      logic meta;
      logic sync;
   } sync_state_t;

endpackage

/* File: pin_sync.sv */
/*
 * Two flip-flop synchroniser for one asynchronous pin.
 * Assumes the pin is asynchronous to i_clk; only the second stage is read.
 */
`timescale 1ns/1ps
module pin_sync (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_srst,
   // Pin and synchronised level
   input  wire logic i_pin,
   output logic      o_level
);
   spi_pkg::sync_state_t st_ff;
   spi_pkg::sync_state_t nxt_st;

   // Next stage values
   always_comb begin
      nxt_st.meta = i_pin;
      nxt_st.sync = st_ff.meta;
   end

   // Stage registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_level = st_ff.sync;
endmodule // pin_sync

/* File: tick_divider.sv */
/*
 * Divider that makes the channel operation clock as a one-cycle enable.
 * Assumes a free-running i_clk; DIV of 1 gives a tick every cycle.
 */
`timescale 1ns/1ps
`include "spi_consts.svh"
module tick_divider #(
   parameter int DIV = `FMCK_DIV
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_srst,
   // Operation clock enable
   output logic      o_tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;

   // Refuse a divider that cannot make a tick
   if (DIV < 1) begin : g_chk
      $error("tick_divider: DIV must be at least 1");
   end

   // Wrap counter
   always_comb begin
      if (cnt_ff == CW'(DIV - 1)) begin
         nxt_cnt = '0;
      end else begin
         nxt_cnt = cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign o_tick = (cnt_ff == CW'(DIV - 1));
endmodule // tick_divider

/* File: slave_select_serial_channel.sv */
/*
 * Slave-side serial channel with slave select, receive-only or full duplex,
 * 7- or 8-bit frames, behind an APB slave with zero wait states.
 * Register map, one 32-bit word each: data 0x00, mode 0x04, start 0x08,
 * stop 0x0C, status 0x10, flag clear 0x14, output enable 0x18,
 * input switch 0x1C, peripheral clock 0x20.
 * Mode bits: 0 full duplex, 1 continuous, 2 data phase, 3 clock polarity,
 * 4 LSB first, 5 seven-bit frame.
 * Status bits: 0 running, 1 frame in progress, 2 overrun, 3 transmit
 * byte waiting, 4 receive byte waiting.
 * Assumes an external master drives the serial clock and select pins,
 * asynchronous to i_clk, at no more than one sixth of the operation clock.
 */
// Behaviour
// - Receive-only raises transfer-end interrupt only.
// - Full duplex: transfer-end single, buffer-empty continuous.
// - Overrun is the only detected error.
// - Serial clock sampled by operation clock, max sixth.
// - Data phase moves I/O start half clock.
// - Receive-only data phase moves input start.
// - Polarity bit inverts serial clock.
// - Select enable bit 7 honours select pin.
// - Peripheral clock off resets whole unit.
// - Deselected: no shift, no sample.
// - Selected: shift one edge, sample other.
// - Byte data is low byte of word.
`timescale 1ns/1ps
`include "spi_consts.svh"
module slave_select_serial_channel #(
   parameter int FMCK_DIV = `FMCK_DIV
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Serial pins
   input  wire logic        i_serial_clock_pin,
   input  wire logic        i_serial_data_in_pin,
   input  wire logic        i_slave_select_pin_n,
   output logic             o_serial_data_out_pin,
   output logic             o_serial_data_out_oe,
   // Events
   output logic             o_channel_interrupt
);
   // ------------------------------------------------------------------
   // Pin synchronisers and operation clock
   // ------------------------------------------------------------------
   logic sck_s;
   logic sdi_s;
   logic ssn_s;
   logic tick;

   // Every input pin passes two flip-flops; only the second stage is read
   pin_sync u_sync_sck (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_pin   (i_serial_clock_pin),
      .o_level (sck_s)
   );

   pin_sync u_sync_sdi (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_pin   (i_serial_data_in_pin),
      .o_level (sdi_s)
   );

   pin_sync u_sync_ssn (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_pin   (i_slave_select_pin_n),
      .o_level (ssn_s)
   );

   // Refuse a divider that leaves no operation clock
   if (FMCK_DIV < 1) begin : g_chk_div
      $error("slave_select_serial_channel: FMCK_DIV must be at least 1");
   end

   // Operation clock enable; a divider of 1 ticks every cycle
   tick_divider #(
      .DIV (FMCK_DIV)
   ) u_tick (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .o_tick (tick)
   );

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   spi_pkg::chan_state_t st_ff;
   spi_pkg::chan_state_t nxt_st;

   logic apb_setup;
   logic apb_acc;
   logic wr_acc;
   logic rd_data_acc;
   logic mapped;

   // APB phase decode
   assign apb_setup   = i_psel & ~i_penable;
   assign apb_acc     = i_psel & i_penable;
   assign wr_acc      = apb_acc & i_pwrite & mapped;
   assign rd_data_acc = apb_acc & ~i_pwrite & (i_paddr == `OFF_DATA);

   // Address map check
   always_comb begin
      case (i_paddr)
         `OFF_DATA, `OFF_MODE, `OFF_START, `OFF_STOP, `OFF_STATUS,
         `OFF_FLAGCLR, `OFF_OUTEN, `OFF_INSW, `OFF_PERIPH: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Output bit of a shift register for the current direction and length
   function automatic logic out_bit(input logic [7:0] sh, input logic lsb,
                                    input logic len7);
      logic b;
      b = lsb ? sh[0] : (len7 ? sh[6] : sh[7]);
      return b;
   endfunction

   // ------------------------------------------------------------------
   // Next-state logic: bus first, then hardware events so a set wins
   // ------------------------------------------------------------------
   always_comb begin
      logic       txrx;
      logic       cont;
      logic       dap;
      logic       lsb;
      logic       len7;
      logic       sck_eff;
      logic       rise;
      logic       fall;
      logic       sel;
      logic       samp_edge;
      logic       shift_edge;
      logic [2:0] last_cnt;
      logic [7:0] rx_new;
      logic       pe;
      logic [31:0] rd;
      // Mode fields and serial clock edges on the operation clock
      txrx       = st_ff.mode[`MODE_TXRX];
      cont       = st_ff.mode[`MODE_CONT];
      dap        = st_ff.mode[`MODE_DAP];
      lsb        = st_ff.mode[`MODE_LSB];
      len7       = st_ff.mode[`MODE_LEN7];
      sck_eff    = sck_s ^ st_ff.mode[`MODE_CKP];
      rise       = tick & sck_eff & ~st_ff.sck_prev;
      fall       = tick & ~sck_eff & st_ff.sck_prev;
      sel        = ~st_ff.insw[`INSW_SEL_EN] | ~ssn_s;
      samp_edge  = dap ? rise : fall;
      shift_edge = dap ? fall : rise;
      last_cnt   = len7 ? 3'h6 : 3'h7;
      rx_new     = lsb ? {sdi_s, st_ff.rx_sh[7:1]} : {st_ff.rx_sh[6:0], sdi_s};
      rd         = 32'h0000_0000;
      pe         = 1'b0;
      // Hold everything by default; the interrupt is a one-cycle pulse
      nxt_st     = st_ff;
      nxt_st.irq = 1'b0;

      // Read mux, captured in the setup phase so that it stands through the
      // access phase; a data read clears the receive flag at the access edge
      case (i_paddr)
         `OFF_DATA:   rd = {24'h00_0000, st_ff.rx_data};
         `OFF_MODE:   rd = {26'h000_0000, st_ff.mode};
         `OFF_STATUS: rd = {27'h000_0000, st_ff.rx_full, st_ff.tx_full, st_ff.ovf,
                            (st_ff.lstate == spi_pkg::ST_FRAME), st_ff.op_en};
         `OFF_OUTEN:  rd = {31'h0000_0000, st_ff.soe};
         `OFF_INSW:   rd = {24'h00_0000, st_ff.insw};
         `OFF_PERIPH: rd = {31'h0000_0000, st_ff.per_en};
         default:     rd = 32'h0000_0000;
      endcase
      if (apb_setup) begin
         nxt_st.prdata = rd;
      end

      // Register writes; unmapped addresses are dropped and answered
      // with a slave error instead
      if (wr_acc) begin
         case (i_paddr)
            `OFF_DATA: begin
               nxt_st.tx_buf  = i_pwdata[7:0];
               nxt_st.tx_full = 1'b1;
            end
            `OFF_MODE:    nxt_st.mode = i_pwdata[5:0];
            `OFF_START: begin
               if (i_pwdata[`TRIG_CH0]) begin
                  nxt_st.op_en = 1'b1;
               end
            end
            `OFF_STOP: begin
               if (i_pwdata[`TRIG_CH0]) begin
                  nxt_st.op_en = 1'b0;
               end
            end
            `OFF_FLAGCLR: begin
               if (i_pwdata[`ST_OVF]) begin
                  nxt_st.ovf = 1'b0;
               end
            end
            `OFF_OUTEN:   nxt_st.soe = i_pwdata[0];
            `OFF_INSW:    nxt_st.insw = {i_pwdata[7], 5'h00, i_pwdata[1:0]};
            `OFF_PERIPH:  nxt_st.per_en = i_pwdata[0];
            default: begin
            end
         endcase
      end
      if (rd_data_acc) begin
         nxt_st.rx_full = 1'b0;
      end

      // Serial clock history on the operation clock
      if (tick) begin
         nxt_st.sck_prev = sck_eff;
      end

      // Serial engine. Edges come only from the synchronised pin, so a
      // serial clock faster than a sixth of the operation clock loses edges.
      // Deselect aborts a frame; the partial byte is dropped, not delivered.
      if (!st_ff.op_en) begin
         nxt_st.lstate = spi_pkg::ST_IDLE;
         nxt_st.bitcnt = 3'h0;
      end else begin
         // Data phase 1: the first bit goes out as soon as a byte waits,
         // even while deselected; continuous mode reports buffer empty here
         if (dap && txrx && st_ff.tx_full && !wr_acc &&
             st_ff.lstate == spi_pkg::ST_IDLE) begin
            nxt_st.tx_sh   = st_ff.tx_buf;
            nxt_st.tx_full = 1'b0;
            nxt_st.irq     = cont;
         end
         if (!sel) begin
            nxt_st.lstate = spi_pkg::ST_IDLE;
            nxt_st.bitcnt = 3'h0;
         end else if (shift_edge) begin
            if (st_ff.lstate == spi_pkg::ST_FRAME) begin
               nxt_st.tx_sh = lsb ? {1'b1, st_ff.tx_sh[7:1]}
                                  : {st_ff.tx_sh[6:0], 1'b1};
            end else if (!dap) begin
               // First shift edge of data phase 0 starts the frame
               nxt_st.lstate = spi_pkg::ST_FRAME;
               if (txrx && st_ff.tx_full && !wr_acc) begin
                  nxt_st.tx_sh   = st_ff.tx_buf;
                  nxt_st.tx_full = 1'b0;
                  nxt_st.irq     = cont;
               end
            end
         end else if (samp_edge &&
                      (dap || st_ff.lstate == spi_pkg::ST_FRAME)) begin
            nxt_st.rx_sh = rx_new;
            // Last bit: deliver the byte; an unread byte is overrun
            if (st_ff.bitcnt == last_cnt) begin
               nxt_st.lstate = spi_pkg::ST_IDLE;
               nxt_st.bitcnt = 3'h0;
               if (lsb && len7) begin
                  nxt_st.rx_data = {1'b0, rx_new[7:1]};
               end else if (len7) begin
                  nxt_st.rx_data = {1'b0, rx_new[6:0]};
               end else begin
                  nxt_st.rx_data = rx_new;
               end
               if (st_ff.rx_full && !rd_data_acc) begin
                  nxt_st.ovf = 1'b1;
               end
               nxt_st.rx_full = 1'b1;
               if (!txrx || !cont) begin
                  nxt_st.irq = 1'b1;
               end
            end else begin
               nxt_st.lstate = spi_pkg::ST_FRAME;
               nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
            end
         end
      end

      // Serial output level, from the next mode and enable so that the
      // pin goes idle in the same cycle as the output enable falls
      if (nxt_st.mode[`MODE_TXRX] && nxt_st.soe) begin
         nxt_st.sdo = out_bit(nxt_st.tx_sh, nxt_st.mode[`MODE_LSB],
                              nxt_st.mode[`MODE_LEN7]);
      end else begin
         nxt_st.sdo = `IDLE_OUT;
      end

      // Peripheral clock off holds the whole unit in reset. Writes made
      // meanwhile are lost; only the enable and the read data survive so
      // that software can turn the unit back on and read it
      if (!nxt_st.per_en) begin
         pe            = nxt_st.per_en;
         rd            = nxt_st.prdata;
         nxt_st        = '0;
         nxt_st.mode   = `MODE_RST;
         nxt_st.insw   = `INSW_RST;
         nxt_st.sdo    = `IDLE_OUT;
         nxt_st.per_en = pe;
         nxt_st.prdata = rd;
      end
   end

   // State register; reset clears all flags and idles the output high
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_ff      <= '0;
         st_ff.mode <= `MODE_RST;
         st_ff.insw <= `INSW_RST;
         st_ff.sdo  <= `IDLE_OUT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_prdata              = st_ff.prdata;
   // Every access completes in one cycle, so ready is constant
   assign o_pready              = 1'b1;
   assign o_pslverr             = apb_acc & ~mapped;
   assign o_serial_data_out_pin = st_ff.sdo;
   // The data pin is driven only in full duplex with its enable set
   assign o_serial_data_out_oe  = st_ff.soe & st_ff.mode[`MODE_TXRX];
   assign o_channel_interrupt   = st_ff.irq;
endmodule // slave_select_serial_channel

/* File: sssc_assertions.sv */
/* Port checker of the slave-select serial channel.
   Assumes it is bound to the channel top and sees its ports only. */
`timescale 1ns/1ps
module sssc_assertions #(
   parameter int FMCK_DIV = 1
) (
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_srst,
   // APB side
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   // Serial side
   input wire logic        i_serial_clock_pin,
   input wire logic        i_slave_select_pin_n,
   input wire logic        o_serial_data_out_pin,
   input wire logic        o_serial_data_out_oe,
   input wire logic        o_channel_interrupt
);
   // ----------------------------------------------------------------
   // Cycles since the last pin change or register access
   // ----------------------------------------------------------------
   logic [6:0] since_ff;
   always_ff @(posedge i_clk) begin
      if (i_srst || (i_psel && i_penable) || $changed(i_serial_clock_pin)
          || $changed(i_slave_select_pin_n))
         since_ff <= 7'h00;
      else if (since_ff < 7'h63)
         since_ff <= since_ff + 7'h01;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_irq_pulse;
      o_channel_interrupt |=> !o_channel_interrupt;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("interrupt longer than one cycle");
   property p_irq_cause;
      o_channel_interrupt |-> since_ff <= 7'h08;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without a serial or bus event");
   property p_sdo_cause;
      $changed(o_serial_data_out_pin) |-> since_ff <= 7'h06;
   endproperty
   a_sdo_cause: assert property (p_sdo_cause)
      else $error("data out moved without a cause");
   property p_oe_cause;
      $changed(o_serial_data_out_oe) |-> $past(i_psel && i_penable && i_pwrite);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("output enable moved without a write");
   property p_oe_idle;
      !o_serial_data_out_oe |-> o_serial_data_out_pin;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("data out not idle while released");
   property p_ready;
      o_pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready low");
   property p_slverr;
      o_pslverr |-> i_psel && i_penable;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("error outside access phase");
   property p_err_rd;
      o_pslverr && !i_pwrite |-> o_prdata == 32'h00000000;
   endproperty
   a_err_rd: assert property (p_err_rd)
      else $error("unmapped read not zero");
   property p_rd_hold;
      !(i_psel && !i_penable) |=> $stable(o_prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved outside setup");

   c_irq: cover property (o_channel_interrupt);
   c_err: cover property (o_pslverr);
   c_oe: cover property ($rose(o_serial_data_out_oe));
endmodule // sssc_assertions

/* File: serial_master_model.sv */
/* Behavioural serial master driving clock, select and data.
   Assumes it is driven by hierarchical task calls from the bench. */
`timescale 1ns/1ps
module serial_master_model (
   // Serial lines toward the channel
   output logic      o_sck,
   output logic      o_mosi,
   output logic      o_ss_n,
   input  wire logic i_miso
);
   // Idle lines at time zero
   initial begin
      o_sck = 1'b0;
      o_mosi = 1'b1;
      o_ss_n = 1'b1;
   end

   // One frame of 80 ns bits, off the bench clock phase
   task automatic xfer(input logic [7:0] tx, input logic len7, lsb, ckp, dap,
                       input logic hold_ss, output logic [7:0] rx);
      int n;
      int k;
      n = len7 ? 7 : 8;
      rx = 8'h00;
      #1.3;
      o_sck = ckp;
      o_ss_n = hold_ss;
      #40;
      for (int i = 0; i < n; i++) begin
         k = lsb ? i : n - 1 - i;
         o_mosi = tx[k];
         #30;
         if (dap)
            rx[k] = i_miso;
         o_sck = ~ckp;
         #40;
         if (!dap)
            rx[k] = i_miso;
         o_sck = ckp;
         #10;
      end
      #30;
      o_ss_n = 1'b1;
      o_mosi = ~o_mosi;
   endtask
endmodule // serial_master_model

/* File: tb_spi_slave_select_rx_txrx.sv */
/* Self-checking bench of the slave-select serial channel.
   Assumes the channel, the checker and the serial master model. */
`timescale 1ns/1ps
`include "spi_consts.svh"
module tb_spi_slave_select_rx_txrx;
   logic        i_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic        pready, pslverr, err, sck, mosi, ss_n, sdo, oe, irq;
   logic [7:0]  mrx;
   int          mismatches = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          irq_cnt = 0;
   int          n0;
   wire         miso = oe ? sdo : 1'b1;

   // Clock, watchdog and interrupt count
   always #2 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1)
         irq_cnt <= irq_cnt + 1;
      if (cyc == 40000) begin
         mismatches++;
         test_done();
      end
   end

   slave_select_serial_channel #(.FMCK_DIV(1)) dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_serial_clock_pin(sck),
      .i_serial_data_in_pin(mosi), .i_slave_select_pin_n(ss_n),
      .o_serial_data_out_pin(sdo), .o_serial_data_out_oe(oe), .o_channel_interrupt(irq));
   serial_master_model master (.o_sck(sck), .o_mosi(mosi), .o_ss_n(ss_n), .i_miso(miso));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1)
         @(posedge i_clk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic frame(input logic [5:0] md, input logic [7:0] mb, sb, input logic hold);
      n0 = irq_cnt;
      apb(1'b1, `OFF_MODE, {26'h0, md});
      if (md[`MODE_TXRX])
         apb(1'b1, `OFF_DATA, {24'h0, sb});
      master.xfer(mb, md[`MODE_LEN7], md[`MODE_LSB], md[`MODE_CKP], md[`MODE_DAP],
                  hold, mrx);
      for (int i = 0; i < 100 && irq_cnt == n0; i++)
         @(posedge i_clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, `OFF_MODE, 32'h0);
      chk("mode reset", r, 32'h0);
      apb(1'b0, `OFF_INSW, 32'h0);
      chk("insw reset", r, 32'h0);
      apb(1'b1, `OFF_INSW, 32'hFFFFFFFF);
      apb(1'b0, `OFF_INSW, 32'h0);
      chk("insw fields", r, 32'h83);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, `OFF_INSW, 32'h80);
      apb(1'b1, `OFF_OUTEN, 32'h1);
      apb(1'b1, `OFF_START, 32'h1);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("enabled", r, 32'h1);
   endtask

   task automatic t_modes;
      logic [5:0] md;
      logic [7:0] mb, sb, ex;
      for (int i = 0; i < 32; i++) begin
         md = {i[4:1], 1'b0, i[0]};
         mb = 8'hA5 ^ 8'(i * 7);
         sb = 8'h3C + 8'(i);
         frame(md, mb, sb, 1'b0);
         chk("irq count", irq_cnt, n0 + 1);
         apb(1'b0, `OFF_DATA, 32'h0);
         ex = md[`MODE_LEN7] ? {1'b0, mb[6:0]} : mb;
         chk("slave rx", r, {24'h0, ex});
         chk("output enable", {31'h0, oe}, {31'h0, md[0]});
         ex = md[`MODE_LEN7] ? {1'b0, sb[6:0]} : sb;
         if (md[`MODE_TXRX])
            chk("master rx", {24'h0, mrx}, {24'h0, ex});
      end
   endtask

   task automatic t_cont;
      frame(6'h03, 8'h5A, 8'hC3, 1'b0);
      repeat (20) @(posedge i_clk);
      chk("buffer empty irq", irq_cnt, n0 + 1);
      chk("cont master rx", {24'h0, mrx}, 32'hC3);
      apb(1'b0, `OFF_DATA, 32'h0);
   endtask

   task automatic t_ovr;
      frame(6'h00, 8'h11, 8'h00, 1'b0);
      frame(6'h00, 8'h22, 8'h00, 1'b0);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("overrun set", {31'h0, r[`ST_OVF]}, 32'h1);
      apb(1'b1, `OFF_FLAGCLR, 32'h4);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("overrun clear", {31'h0, r[`ST_OVF]}, 32'h0);
      apb(1'b0, `OFF_DATA, 32'h0);
   endtask

   task automatic t_ss;
      frame(6'h00, 8'h77, 8'h00, 1'b1);
      chk("deselected irq", irq_cnt, n0);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("deselected rx", {31'h0, r[`ST_RXFULL]}, 32'h0);
      apb(1'b1, `OFF_INSW, 32'h00);
      frame(6'h00, 8'h96, 8'h00, 1'b1);
      apb(1'b0, `OFF_DATA, 32'h0);
      chk("select ignored", r, 32'h96);
      apb(1'b1, `OFF_INSW, 32'h80);
   endtask

   task automatic t_stop;
      apb(1'b1, `OFF_STOP, 32'h1);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("stopped", r, 32'h0);
      frame(6'h01, 8'h44, 8'h55, 1'b0);
      chk("stopped irq", irq_cnt, n0);
      apb(1'b1, `OFF_OUTEN, 32'h0);
      @(posedge i_clk);
      chk("output off", {31'h0, oe}, 32'h0);
      apb(1'b1, `OFF_PERIPH, 32'h0);
      apb(1'b1, `OFF_MODE, 32'h3F);
      apb(1'b1, `OFF_PERIPH, 32'h1);
      apb(1'b0, `OFF_MODE, 32'h0);
      chk("unit reset mode", r, 32'h0);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("unit reset status", r, 32'h0);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      i_srst <= 1'b0;
      apb(1'b1, `OFF_PERIPH, 32'h1);
      t_regs();
      t_modes();
      t_cont();
      t_ovr();
      t_ss();
      t_stop();
      test_done();
   end
endmodule // tb_spi_slave_select_rx_txrx

bind slave_select_serial_channel sssc_assertions #(.FMCK_DIV(FMCK_DIV)) chk_i (
   .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_serial_clock_pin(i_serial_clock_pin), .i_slave_select_pin_n(i_slave_select_pin_n),
   .o_serial_data_out_pin(o_serial_data_out_pin),
   .o_serial_data_out_oe(o_serial_data_out_oe), .o_channel_interrupt(o_channel_interrupt));
